// File: hw/hotswap_i2c_pkg.sv
/*
  constants, state type and address-pin decode for the i2c/smbus slave port.
  assumes a single 100 MHz core clock; the bus master owns scl.
*/
package hotswap_i2c_pkg;

  // ------------------------------------------------------------
  // register offsets and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] REG_DEVICE_CONTROL = 8'h00;
  localparam logic [7:0] REG_ALERT_ENABLE_MASK = 8'h02;
  localparam logic [7:0] REG_FAULT_RECORD = 8'h04;
  localparam logic [7:0] REG_LIVE_STATUS = 8'h1F;
  localparam logic [7:0] REG_ADC_SNAP_BASE = 8'h40;
  localparam int ADC_SNAP_BYTES = 6;
  localparam int ADC_BITS = 48;
  localparam int CTRL_MASS_WRITE_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h10;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FAULT_RESET = 8'h00;

  // ------------------------------------------------------------
  // bus addresses
  // ------------------------------------------------------------
  localparam logic [7:0] MASS_WRITE_ADDR = 8'hBE;
  localparam logic [7:0] ALERT_RESPONSE_ADDR = 8'h19;
  localparam logic [1:0] ADDR_HIGH_BITS = 2'b10;

  // ------------------------------------------------------------
  // address-select pins: two bits per pin, pin 2 in the top pair
  // ------------------------------------------------------------
  localparam int ADR_PIN_BITS = 6;
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_HIGH = 2'h1;
  localparam logic [1:0] PIN_OPEN = 2'h2;
  localparam logic [1:0] ADR_SETTLE = 2'h3;
  localparam logic [4:0] ADDR_FALLBACK = 5'h0A;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_RX,
    ST_ACK_RX,
    ST_TX,
    ST_ACK_TX,
    ST_NEXT_TX
  } i2c_state_t;

  function automatic logic [4:0] decode_addr_select(input logic [5:0] p);
    logic [4:0] a;
    a = ADDR_FALLBACK;
    case (p)
      {PIN_LOW, PIN_OPEN, PIN_LOW}: a = 5'h00;
      {PIN_LOW, PIN_HIGH, PIN_OPEN}: a = 5'h01;
      {PIN_LOW, PIN_OPEN, PIN_OPEN}: a = 5'h02;
      {PIN_LOW, PIN_OPEN, PIN_HIGH}: a = 5'h03;
      {PIN_LOW, PIN_LOW, PIN_LOW}: a = 5'h04;
      {PIN_LOW, PIN_HIGH, PIN_HIGH}: a = 5'h05;
      {PIN_LOW, PIN_LOW, PIN_OPEN}: a = 5'h06;
      {PIN_LOW, PIN_LOW, PIN_HIGH}: a = 5'h07;
      {PIN_OPEN, PIN_OPEN, PIN_LOW}: a = 5'h08;
      {PIN_OPEN, PIN_HIGH, PIN_OPEN}: a = 5'h09;
      {PIN_OPEN, PIN_OPEN, PIN_OPEN}: a = 5'h0A;
      {PIN_OPEN, PIN_OPEN, PIN_HIGH}: a = 5'h0B;
      {PIN_OPEN, PIN_LOW, PIN_LOW}: a = 5'h0C;
      {PIN_OPEN, PIN_HIGH, PIN_HIGH}: a = 5'h0D;
      {PIN_OPEN, PIN_LOW, PIN_OPEN}: a = 5'h0E;
      {PIN_OPEN, PIN_LOW, PIN_HIGH}: a = 5'h0F;
      {PIN_HIGH, PIN_OPEN, PIN_LOW}: a = 5'h10;
      {PIN_HIGH, PIN_HIGH, PIN_OPEN}: a = 5'h11;
      {PIN_HIGH, PIN_OPEN, PIN_OPEN}: a = 5'h12;
      {PIN_HIGH, PIN_OPEN, PIN_HIGH}: a = 5'h13;
      {PIN_HIGH, PIN_LOW, PIN_LOW}: a = 5'h14;
      {PIN_HIGH, PIN_HIGH, PIN_HIGH}: a = 5'h15;
      {PIN_HIGH, PIN_LOW, PIN_OPEN}: a = 5'h16;
      {PIN_HIGH, PIN_LOW, PIN_HIGH}: a = 5'h17;
      {PIN_LOW, PIN_HIGH, PIN_LOW}: a = 5'h18;
      {PIN_OPEN, PIN_HIGH, PIN_LOW}: a = 5'h19;
      {PIN_HIGH, PIN_HIGH, PIN_LOW}: a = 5'h1A;
      default: a = ADDR_FALLBACK;
    endcase
    return a;
  endfunction

endpackage

// File: hw/pin_sync2.sv
/*
  two-flop synchroniser for a vector of pins.
  assumes each bit is an independent level; no bus coherence is implied.
*/
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;
endmodule // pin_sync2

// File: hw/hotswap_i2c_smbus_slave_port.sv
/*
  i2c/smbus slave port giving a bus master byte access to the monitor
  registers, with mass write, alert response and adc result freezing.
  assumes scl/sda arrive asynchronously and are oversampled by the 100 MHz
  core clock; fault, status and adc inputs come from same-clock logic.
*/
`timescale 1ns/1ps
module hotswap_i2c_smbus_slave_port (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic alert_out,
  output logic alert_oe_out,
  input wire logic [hotswap_i2c_pkg::ADR_PIN_BITS-1:0]
    slave_addr_select_pins_in,
  input wire logic [7:0] fault_event_in,
  input wire logic [7:0] status_in,
  input wire logic [hotswap_i2c_pkg::ADC_BITS-1:0] adc_result_in,
  input wire logic adc_valid_in,
  output logic [7:0] device_control_out,
  output logic bus_busy_out
);
  import hotswap_i2c_pkg::*;

  // ------------------------------------------------------------
  // pin sampling and bus condition detection
  // ------------------------------------------------------------
  logic [ADR_PIN_BITS+1:0] pin_sync;
  logic scl_s, sda_s, scl_prev_reg, sda_prev_reg;
  logic scl_rise, scl_fall, start_det, stop_det;

  pin_sync2 #(
    .WIDTH(ADR_PIN_BITS + 2),
    .RESET_VALUE({2'b11, {ADR_PIN_BITS{1'b0}}})
  ) u_pin_sync (
    .clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .d_in({scl_in, sda_in, slave_addr_select_pins_in}),
    .q_out(pin_sync)
  );

  assign scl_s = pin_sync[ADR_PIN_BITS+1];
  assign sda_s = pin_sync[ADR_PIN_BITS];

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ------------------------------------------------------------
  // slave address, caught once after reset release
  // ------------------------------------------------------------
  logic [1:0] settle_reg;
  logic [4:0] addr_low_reg;
  logic [6:0] own_addr;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      settle_reg <= 2'h0;
      addr_low_reg <= 5'h00;
    end else if (settle_reg != ADR_SETTLE) begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == ADR_SETTLE - 2'h1) begin
        addr_low_reg <= decode_addr_select(pin_sync[ADR_PIN_BITS-1:0]);
      end
    end
  end

  assign own_addr = {ADDR_HIGH_BITS, addr_low_reg};

  // ------------------------------------------------------------
  // byte engine
  // ------------------------------------------------------------
  i2c_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg, rx_byte, tx_byte, rd_data, ptr_reg;
  logic ack_armed_reg, rw_reg, ara_reg, cmd_phase_reg, sda_oe_reg;
  logic hit_own, hit_mass, hit_ara, addr_done, rx_done, tx_acked;
  logic ara_done, alert_reg;
  logic [7:0] dev_ctrl_reg;

  assign rx_byte = {shift_reg[6:0], sda_s};
  assign addr_done = (state_reg == ST_ADDR) && scl_rise
    && (bit_cnt_reg == 3'h7);
  assign rx_done = (state_reg == ST_RX) && scl_rise && (bit_cnt_reg == 3'h7);
  assign tx_acked = (state_reg == ST_ACK_TX) && scl_rise && !sda_s;
  assign ara_done = (state_reg == ST_ACK_TX) && scl_rise && ara_reg;
  assign tx_byte = ara_reg ? {own_addr, 1'b0} : rd_data;

  always_comb begin
    hit_own = (rx_byte[7:1] == own_addr);
    hit_mass = (rx_byte == MASS_WRITE_ADDR)
      && dev_ctrl_reg[CTRL_MASS_WRITE_BIT];
    hit_ara = (rx_byte == ALERT_RESPONSE_ADDR) && alert_reg;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      ack_armed_reg <= 1'b0;
      rw_reg <= 1'b0;
      ara_reg <= 1'b0;
      cmd_phase_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 3'h0;
      ack_armed_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              if (state_reg == ST_RX) begin
                state_reg <= ST_ACK_RX;
                cmd_phase_reg <= 1'b0;
              end else if (hit_own || hit_mass || hit_ara) begin
                state_reg <= ST_ACK_ADDR;
                rw_reg <= rx_byte[0];
                ara_reg <= hit_ara;
                cmd_phase_reg <= ~rx_byte[0];
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_RX: begin
          if (scl_fall) begin
            ack_armed_reg <= ~ack_armed_reg;
            bit_cnt_reg <= 3'h0;
            if (!ack_armed_reg) begin
              sda_oe_reg <= 1'b1;
            end else if (state_reg == ST_ACK_ADDR && rw_reg) begin
              state_reg <= ST_TX;
              shift_reg <= tx_byte;
              sda_oe_reg <= ~tx_byte[7];
            end else begin
              state_reg <= ST_RX;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 3'h7) begin
              state_reg <= ST_ACK_TX;
              sda_oe_reg <= 1'b0;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= ~shift_reg[6];
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_rise) begin
            state_reg <= (tx_acked && !ara_reg) ? ST_NEXT_TX : ST_IDLE;
          end
        end
        ST_NEXT_TX: begin
          if (scl_fall) begin
            state_reg <= ST_TX;
            bit_cnt_reg <= 3'h0;
            shift_reg <= tx_byte;
            sda_oe_reg <= ~tx_byte[7];
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // register pointer and writable registers
  // ------------------------------------------------------------
  logic wr_en;
  logic [7:0] mask_reg, fault_reg, fault_next;

  assign wr_en = rx_done && !cmd_phase_reg;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr_reg <= 8'h00;
    end else if (rx_done && cmd_phase_reg) begin
      ptr_reg <= rx_byte;
    end else if (wr_en) begin
      ptr_reg <= ptr_reg + 8'h01;
    end else if (tx_acked && !ara_reg) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dev_ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
    end else if (wr_en) begin
      if (ptr_reg == REG_DEVICE_CONTROL) begin
        dev_ctrl_reg <= rx_byte;
      end
      if (ptr_reg == REG_ALERT_ENABLE_MASK) begin
        mask_reg <= rx_byte;
      end
    end
  end

  // new fault events win over a software write in the same cycle
  always_comb begin
    fault_next = fault_reg;
    if (wr_en && ptr_reg == REG_FAULT_RECORD) begin
      fault_next = rx_byte;
    end
    fault_next = fault_next | fault_event_in;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fault_reg <= FAULT_RESET;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // ------------------------------------------------------------
  // adc snapshot, frozen while the bus is busy
  // ------------------------------------------------------------
  logic busy_reg;
  logic [ADC_BITS-1:0] adc_snap_reg;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end else if (stop_det) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      adc_snap_reg <= '0;
    end else if (adc_valid_in && !busy_reg) begin
      adc_snap_reg <= adc_result_in;
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (ptr_reg == REG_DEVICE_CONTROL) begin
      rd_data = dev_ctrl_reg;
    end else if (ptr_reg == REG_ALERT_ENABLE_MASK) begin
      rd_data = mask_reg;
    end else if (ptr_reg == REG_FAULT_RECORD) begin
      rd_data = fault_reg;
    end else if (ptr_reg == REG_LIVE_STATUS) begin
      rd_data = status_in;
    end
    for (int i = 0; i < ADC_SNAP_BYTES; i++) begin
      if (ptr_reg == REG_ADC_SNAP_BASE + 8'(i)) begin
        rd_data = adc_snap_reg[ADC_BITS-1-8*i -: 8];
      end
    end
  end

  // ------------------------------------------------------------
  // alert line
  // ------------------------------------------------------------
  logic alert_req, pin_low_reg;

  assign alert_req = |(fault_next & ~fault_reg & mask_reg);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alert_reg <= 1'b0;
      pin_low_reg <= 1'b0;
    end else begin
      pin_low_reg <= 1'b0;
      if (alert_req) begin
        alert_reg <= 1'b1;
      end else if (ara_done) begin
        alert_reg <= 1'b0;
      end
    end
  end

  assign sda_out = pin_low_reg;
  assign sda_oe_out = sda_oe_reg;
  assign alert_out = pin_low_reg;
  assign alert_oe_out = alert_reg;
  assign device_control_out = dev_ctrl_reg;
  assign bus_busy_out = busy_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence addr_ack_s;
    (state_reg == ST_ACK_ADDR) && scl_fall && !ack_armed_reg;
  endsequence
  sequence tx_start_s;
    (state_reg == ST_ACK_ADDR) && scl_fall && ack_armed_reg && rw_reg;
  endsequence

  ack_addr_drive_a: assert property (addr_ack_s |=> sda_oe_out)
    else $error("address ack not driven");
  ack_rx_drive_a: assert property (
    (state_reg == ST_ACK_RX) && scl_fall && !ack_armed_reg |=> sda_oe_out)
    else $error("data ack not driven");
  tx_first_bit_a: assert property (
    tx_start_s |=> (state_reg == ST_TX) && (sda_oe_out == ~shift_reg[7]))
    else $error("first read bit wrong");
  no_match_a: assert property (
    addr_done && !hit_own && !hit_mass && !hit_ara
    |=> (state_reg == ST_IDLE) && !sda_oe_out)
    else $error("unmatched address not ignored");
  mass_gate_a: assert property (
    addr_done && (rx_byte == MASS_WRITE_ADDR)
    && !dev_ctrl_reg[CTRL_MASS_WRITE_BIT] && !hit_own
    |=> state_reg == ST_IDLE)
    else $error("disabled mass write taken");
  ptr_load_a: assert property (
    rx_done && cmd_phase_reg |=> ptr_reg == $past(rx_byte))
    else $error("pointer not loaded");
  wr_inc_a: assert property (
    rx_done && !cmd_phase_reg |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("write pointer not advanced");
  rd_inc_a: assert property (
    tx_acked && !ara_reg |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("read pointer not advanced");
  adc_freeze_a: assert property (busy_reg |=> $stable(adc_snap_reg))
    else $error("adc snapshot changed while busy");
  alert_set_a: assert property (alert_req |=> alert_oe_out)
    else $error("alert not raised");
  alert_release_a: assert property (
    $fell(alert_reg) |-> $past(ara_done))
    else $error("alert released early");
  alert_quiet_a: assert property (
    !alert_req && !alert_reg |=> !alert_reg)
    else $error("alert raised without new fault");
  start_addr_a: assert property (start_det |=> state_reg == ST_ADDR)
    else $error("start not seen");
endmodule // hotswap_i2c_smbus_slave_port

// File: tb/i2c_master_model.sv
/*
  i2c/smbus bus master model: drives scl and pulls or releases sda.
  assumes a pull-up on sda and a bench that calls its tasks.
*/
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // ----------------------------------------------------------
  // bus phases: 16 core clocks per bit, scl still between frames
  // ----------------------------------------------------------
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // also serves as repeated start when scl is low
  task automatic start;
    sda_out = 1'b1;
    wt(4);
    scl_out = 1'b1;
    wt(8);
    sda_out = 1'b0;
    wt(8);
    scl_out = 1'b0;
    wt(4);
  endtask

  task automatic stop;
    sda_out = 1'b0;
    wt(4);
    scl_out = 1'b1;
    wt(8);
    sda_out = 1'b1;
    wt(8);
  endtask

  task automatic put_bit(input logic b);
    sda_out = b;
    wt(4);
    scl_out = 1'b1;
    wt(8);
    scl_out = 1'b0;
    wt(4);
  endtask

  task automatic get_bit(output logic b);
    sda_out = 1'b1;
    wt(4);
    scl_out = 1'b1;
    wt(4);
    b = sda_in;
    wt(4);
    scl_out = 1'b0;
    wt(4);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask

  // nack only after the last byte wanted
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule // i2c_master_model

// File: tb/tb.sv
/*
  self-checking bench for the i2c/smbus slave port.
  assumes the master model drives the bus and sda has a pull-up.
*/
`timescale 1ns/1ps
module tb;
  import hotswap_i2c_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] pins = '0;
  logic [7:0] fault = '0;
  logic [7:0] status = '0;
  logic [47:0] adc = '0;
  logic adc_v = 1'b0;
  logic scl;
  logic m_sda;
  logic sda_o;
  logic sda_oe;
  logic alert_oe;
  logic alert_o;
  logic busy;
  logic [7:0] ctrl;
  wire sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
  // alert line with its pull-up; low means alert asserted
  wire alert_pin_n = alert_oe ? alert_o : 1'b1;
  int num_errors = 0;
  int n_tests = 0;
  logic [7:0] rb [0:7];
  logic ack;
  logic [6:0] own;

  always #5 clk = ~clk;

  hotswap_i2c_smbus_slave_port hotswap_i2c_smbus_slave_port_inst (
    .core_clk_in(clk), .resetn_in(resetn), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .alert_out(alert_o),
    .alert_oe_out(alert_oe), .slave_addr_select_pins_in(pins),
    .fault_event_in(fault), .status_in(status), .adc_result_in(adc),
    .adc_valid_in(adc_v), .device_control_out(ctrl), .bus_busy_out(busy)
  );

  i2c_master_model i2c_master_model_inst (
    .clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda)
  );

  // ----------------------------------------------------------
  // compares, closing and bus transfers
  // ----------------------------------------------------------
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic check1(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [5:0] p);
    @(negedge clk);
    resetn = 1'b0;
    pins = p;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  task automatic addr_phase(input logic [6:0] a, input logic [7:0] r,
                            input logic ea);
    i2c_master_model_inst.start();
    i2c_master_model_inst.send({a, 1'b0}, ack);
    check1(ack, ea);
    if (ea) begin
      check1(busy, 1'b1);
      i2c_master_model_inst.send(r, ack);
      check1(ack, 1'b1);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] r,
                    input logic [7:0] d0, input logic [7:0] d1,
                    input int n, input logic ea);
    addr_phase(a, r, ea);
    for (int i = 0; i < n && ea; i++) begin
      i2c_master_model_inst.send(i ? d1 : d0, ack);
      check1(ack, 1'b1);
    end
    i2c_master_model_inst.stop();
    check1(busy, 1'b0);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] r, input int n);
    addr_phase(a, r, 1'b1);
    i2c_master_model_inst.start();
    i2c_master_model_inst.send({a, 1'b1}, ack);
    check1(ack, 1'b1);
    for (int i = 0; i < n; i++)
      i2c_master_model_inst.recv(i == n - 1, rb[i]);
    i2c_master_model_inst.stop();
  endtask

  task automatic ara(input logic ea);
    i2c_master_model_inst.start();
    i2c_master_model_inst.send(ALERT_RESPONSE_ADDR, ack);
    check1(ack, ea);
    if (ea) begin
      check1(alert_oe, 1'b1);
      i2c_master_model_inst.recv(1'b1, rb[0]);
      check8(rb[0], {own, 1'b0});
    end
    i2c_master_model_inst.stop();
    check1(alert_oe, 1'b0);
  endtask

  task automatic fault_pulse(input logic [7:0] f, input logic e);
    fault = f;
    @(negedge clk);
    fault = '0;
    repeat (4) @(negedge clk);
    check1(alert_oe, e);
    check1(alert_pin_n, !e);
  endtask

  task automatic adc_load(input logic [47:0] v);
    adc = v;
    adc_v = 1'b1;
    @(negedge clk);
    adc_v = 1'b0;
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial begin
    #300_000;
    num_errors++;
    report_and_stop;
  end

  initial begin
    do_reset({PIN_HIGH, PIN_OPEN, PIN_HIGH});
    own = 7'b1010011;
    check8(ctrl, 8'h10);
    check1(alert_oe, 1'b0);
    rd(own, 8'h00, 5);
    check8(rb[0], 8'h10);
    check8(rb[2], 8'h00);
    check8(rb[4], 8'h00);
    wr(own, 8'h02, 8'h01, 8'h5A, 2, 1'b1);
    rd(own, 8'h02, 2);
    check8(rb[0], 8'h01);
    check8(rb[1], 8'h00);
    wr(7'h5F, 8'h02, 8'h03, 8'h00, 1, 1'b1);
    wr(own, 8'h00, 8'h00, 8'h00, 1, 1'b1);
    check8(ctrl, 8'h00);
    wr(7'h5F, 8'h02, 8'hFF, 8'h00, 1, 1'b0);
    wr(own, 8'h00, 8'h10, 8'h00, 1, 1'b1);
    rd(own, 8'h02, 1);
    check8(rb[0], 8'h03);
    wr(7'h54, 8'h02, 8'h00, 8'h00, 1, 1'b0);
    ara(1'b0);
    fault_pulse(8'h04, 1'b0);
    fault_pulse(8'h01, 1'b1);
    rd(own, REG_FAULT_RECORD, 1);
    check8(rb[0], 8'h05);
    ara(1'b1);
    fault_pulse(8'h01, 1'b0);
    fault_pulse(8'h02, 1'b1);
    ara(1'b1);
    wr(own, REG_FAULT_RECORD, 8'h00, 8'h00, 1, 1'b1);
    fault_pulse(8'h01, 1'b1);
    ara(1'b1);
    status = 8'h3C;
    rd(own, REG_LIVE_STATUS, 1);
    check8(rb[0], 8'h3C);
    adc_load(48'h1122_3344_5566);
    fork
      rd(own, REG_ADC_SNAP_BASE, 6);
      begin
        repeat (100) @(negedge clk);
        status = 8'hC3;
        adc_load(48'hAABB_CCDD_EEFF);
      end
    join
    for (int i = 0; i < 6; i++) check8(rb[i], 8'(8'h11 * (i + 1)));
    rd(own, REG_LIVE_STATUS, 1);
    check8(rb[0], 8'hC3);
    adc_load(48'hAABB_CCDD_EEFF);
    rd(own, REG_ADC_SNAP_BASE, 6);
    for (int i = 0; i < 6; i++) check8(rb[i], 8'(8'hAA + 8'h11 * i));
    wr(own, 8'h00, 8'h00, 8'h00, 1, 1'b1);
    check8(ctrl, 8'h00);
    do_reset({PIN_LOW, PIN_OPEN, PIN_LOW});
    check8(ctrl, 8'h10);
    rd(7'h40, 8'h00, 1);
    check8(rb[0], 8'h10);
    wr(own, 8'h00, 8'h00, 8'h00, 1, 1'b0);
    report_and_stop;
  end
endmodule // tb
